/* File: rtl/pmsb_regs.sv */
// Supervisor and first step-down converter register bank with its control outputs.
`timescale 1ns/10ps
`default_nettype none

module pmsb_regs #(
    parameter bit AUTO_CLEAR_OFF = 1'b1,
    parameter int SHORT_CYC = pmsb_pkg::TOUT_SHORT_CYC,
    parameter int LONG_CYC = pmsb_pkg::TOUT_LONG_CYC
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Register port from the serial interface.
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Supervisor inputs.
    input wire logic uvlo_i,
    input wire logic supply_ok_i,
    input wire logic low_supply_i,
    input wire logic pushbutton_input_i,
    input wire logic charger_input_valid_i,
    // Converter inputs.
    input wire logic voltage_bank_select_pin_i,
    input wire logic power_good_i,
    input wire logic fault_event_i,
    // Supervisor outputs.
    output logic reset_output_pin_n_o,
    output logic [3:0] supply_threshold_code_o,
    output logic irq_o,
    output logic shutdown_o,
    output logic all_outputs_off_o,
    // Converter outputs.
    output logic [5:0] vout_code_o,
    output logic conv_enable_o,
    output logic conv_phase_o,
    output logic conv_fixed_freq_o,
    output logic [2:0] conv_delay_o
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Merge a write into a register keeping bits outside the mask.
    function automatic logic [7:0] merge_wr(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] msk);
        merge_wr = (old & ~msk) | (wd & msk);
    endfunction

    // True when a write hits the given offset.
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [7:0] sys_ctrl_q, sys_ctrl_d;
    logic [7:0] sys_aux_q, sys_aux_d;
    logic [7:0] vpri_q, vpri_d;
    logic [7:0] vsec_q, vsec_d;
    logic [7:0] c1ctl_q, c1ctl_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic off_clr;

    // Hardware auto-clear of master off; a write of 1 in the same cycle still wins.
    // auto clear condition
    assign off_clr = AUTO_CLEAR_OFF && (pushbutton_input_i || charger_input_valid_i);

    // Next values of the stored registers.
    always_comb begin
        sys_ctrl_d = sys_ctrl_q;
        sys_aux_d = sys_aux_q;
        vpri_d = vpri_q;
        vsec_d = vsec_q;
        c1ctl_d = c1ctl_q;
        if (off_clr) begin
            sys_aux_d[pmsb_pkg::OFF_BIT] = 1'b0;
        end
        if (reg_wr_i) begin
            if (hit(reg_addr_i, pmsb_pkg::OFF_SYS_CTRL)) begin
                sys_ctrl_d = merge_wr(sys_ctrl_q, reg_wdata_i, pmsb_pkg::MASK_SYS_CTRL);
            end
            if (hit(reg_addr_i, pmsb_pkg::OFF_SYS_AUX)) begin
                sys_aux_d = merge_wr(sys_aux_d, reg_wdata_i, pmsb_pkg::MASK_SYS_AUX);
                if (off_clr && !reg_wdata_i[pmsb_pkg::OFF_BIT]) begin
                    sys_aux_d[pmsb_pkg::OFF_BIT] = 1'b0;
                end
            end
            if (hit(reg_addr_i, pmsb_pkg::OFF_C1_VPRI)) begin
                vpri_d = merge_wr(vpri_q, reg_wdata_i, pmsb_pkg::MASK_VCODE);
            end
            if (hit(reg_addr_i, pmsb_pkg::OFF_C1_VSEC)) begin
                vsec_d = merge_wr(vsec_q, reg_wdata_i, pmsb_pkg::MASK_VCODE);
            end
            if (hit(reg_addr_i, pmsb_pkg::OFF_C1_CTL)) begin
                c1ctl_d = merge_wr(c1ctl_q, reg_wdata_i, pmsb_pkg::MASK_C1_CTL);
            end
        end
        if (uvlo_i) begin
            sys_ctrl_d = pmsb_pkg::RST_SYS_CTRL;
            sys_aux_d = pmsb_pkg::RST_SYS_AUX;
            vpri_d = pmsb_pkg::RST_C1_VPRI;
            vsec_d = pmsb_pkg::RST_C1_VSEC;
            c1ctl_d = pmsb_pkg::RST_C1_CTL;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Status bits are sampled at the read, so a read shows the live rail and power-good level.
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = reg_rd_i;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                pmsb_pkg::OFF_SYS_CTRL: begin
                    rdata_d = sys_ctrl_q;
                    rdata_d[pmsb_pkg::LSFLAG_BIT] = low_supply_i;
                end
                pmsb_pkg::OFF_SYS_AUX: begin
                    rdata_d = sys_aux_q;
                end
                pmsb_pkg::OFF_C1_VPRI: begin
                    rdata_d = vpri_q & pmsb_pkg::MASK_VCODE;
                end
                pmsb_pkg::OFF_C1_VSEC: begin
                    rdata_d = vsec_q & pmsb_pkg::MASK_VCODE;
                end
                pmsb_pkg::OFF_C1_CTL: begin
                    rdata_d = c1ctl_q;
                    rdata_d[pmsb_pkg::PGOOD_BIT] = power_good_i;
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic irq_q, irq_d;
    logic shdn_q, shdn_d;
    logic [5:0] vcode_q, vcode_d;

    // Interrupt and shutdown decisions are registered so the pins never glitch on comparator edges.
    always_comb begin
        irq_d = (low_supply_i && sys_ctrl_q[pmsb_pkg::RESP_BIT] && sys_ctrl_q[pmsb_pkg::UNMASK_BIT]) ||
                (fault_event_i && c1ctl_q[pmsb_pkg::FLTEN_BIT]);
        shdn_d = low_supply_i && !sys_ctrl_q[pmsb_pkg::RESP_BIT];
        vcode_d = voltage_bank_select_pin_i ? vsec_q[5:0] : vpri_q[5:0];
    end

    // All registers of the bank.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sys_ctrl_q <= pmsb_pkg::RST_SYS_CTRL;
            sys_aux_q <= pmsb_pkg::RST_SYS_AUX;
            vpri_q <= pmsb_pkg::RST_C1_VPRI;
            vsec_q <= pmsb_pkg::RST_C1_VSEC;
            c1ctl_q <= pmsb_pkg::RST_C1_CTL;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
            irq_q <= 1'b0;
            shdn_q <= 1'b0;
            vcode_q <= pmsb_pkg::RST_C1_VPRI[5:0];
        end else begin
            sys_ctrl_q <= sys_ctrl_d;
            sys_aux_q <= sys_aux_d;
            vpri_q <= vpri_d;
            vsec_q <= vsec_d;
            c1ctl_q <= c1ctl_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            irq_q <= irq_d;
            shdn_q <= shdn_d;
            vcode_q <= vcode_d;
        end
    end

    // Field outputs come straight from the stored flops.
    assign reg_rdata_o = rdata_q;
    assign reg_rvalid_o = rvalid_q;
    assign irq_o = irq_q;
    assign shutdown_o = shdn_q;
    assign vout_code_o = vcode_q;
    assign supply_threshold_code_o = sys_ctrl_q[3:0];
    assign all_outputs_off_o = sys_aux_q[pmsb_pkg::OFF_BIT];
    assign conv_enable_o = c1ctl_q[pmsb_pkg::ON_BIT];
    assign conv_phase_o = c1ctl_q[pmsb_pkg::PHASE_BIT];
    assign conv_fixed_freq_o = c1ctl_q[pmsb_pkg::MODE_BIT];
    assign conv_delay_o = c1ctl_q[pmsb_pkg::DLY_LSB +: 3];

    // ----------------------------------------
    // Reset output timer
    // ----------------------------------------
    // Undervoltage pulls the reset pin back low on the next clock edge whatever the supply input says.
    logic tmr_ok;
    assign tmr_ok = supply_ok_i && !uvlo_i;

    pmsb_rst_timer #(
        .SHORT_CYC(SHORT_CYC),
        .LONG_CYC(LONG_CYC)
    ) u_rst_timer (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .supply_ok_i(tmr_ok),
        .short_sel_i(sys_ctrl_q[pmsb_pkg::TRST_BIT]),
        .reset_out_n_o(reset_output_pin_n_o)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic wr_ctl, wr_aux, rd_ctl;
    assign wr_ctl = reg_wr_i && hit(reg_addr_i, pmsb_pkg::OFF_C1_CTL) && !uvlo_i;
    assign wr_aux = reg_wr_i && hit(reg_addr_i, pmsb_pkg::OFF_SYS_AUX);
    assign rd_ctl = reg_rd_i && hit(reg_addr_i, pmsb_pkg::OFF_SYS_CTRL);

    irq_masked_a: assert property (
        (!sys_ctrl_q[pmsb_pkg::UNMASK_BIT] && !fault_event_i) |=> !irq_o)
        else $error("low-supply interrupt leaked while masked");

    shutdown_mode_a: assert property (
        (low_supply_i && !sys_ctrl_q[pmsb_pkg::RESP_BIT]) |=>
        shutdown_o && irq_o == ($past(fault_event_i) && $past(c1ctl_q[pmsb_pkg::FLTEN_BIT])))
        else $error("low supply did not shut down in shutdown mode");

    flag_read_a: assert property (
        rd_ctl |=> reg_rvalid_o && reg_rdata_o[pmsb_pkg::LSFLAG_BIT] == $past(low_supply_i))
        else $error("low-supply flag read wrong");

    thresh_wr_a: assert property (
        (reg_wr_i && hit(reg_addr_i, pmsb_pkg::OFF_SYS_CTRL) && !uvlo_i) |=>
        supply_threshold_code_o == $past(reg_wdata_i[3:0]))
        else $error("threshold code not stored");

    off_clear_a: assert property (
        (AUTO_CLEAR_OFF && all_outputs_off_o && pushbutton_input_i && !wr_aux) |=> !all_outputs_off_o)
        else $error("master off not auto-cleared");

    uvlo_clear_a: assert property (
        uvlo_i |=> sys_aux_q == pmsb_pkg::RST_SYS_AUX && c1ctl_q == pmsb_pkg::RST_C1_CTL ##1 !reset_output_pin_n_o)
        else $error("undervoltage did not restore defaults");

    bank_sel_a: assert property (
        voltage_bank_select_pin_i |=> vout_code_o == $past(vsec_q[5:0]))
        else $error("secondary code not applied");

    enable_wr_a: assert property (
        (wr_ctl && !reg_wdata_i[pmsb_pkg::ON_BIT]) |=> !conv_enable_o && conv_delay_o == $past(reg_wdata_i[4:2]))
        else $error("converter control write not applied");

    fault_gate_a: assert property (
        (!c1ctl_q[pmsb_pkg::FLTEN_BIT] && !low_supply_i) |=> !irq_o)
        else $error("fault passed while disabled");

    reserved_zero_a: assert property (
        (reg_rd_i && (hit(reg_addr_i, pmsb_pkg::OFF_C1_VPRI) || hit(reg_addr_i, pmsb_pkg::OFF_C1_VSEC)))
        |=> reg_rdata_o[7:6] == 2'b00)
        else $error("reserved voltage-code bits read nonzero");

    pgood_read_a: assert property (
        (reg_rd_i && hit(reg_addr_i, pmsb_pkg::OFF_C1_CTL)) |=> reg_rdata_o[0] == $past(power_good_i))
        else $error("power-good read wrong");

    irq_path_c: cover property (low_supply_i && sys_ctrl_q[pmsb_pkg::UNMASK_BIT] ##1 irq_o);
    shutdown_c: cover property (shdn_d ##1 shutdown_o);
    off_race_c: cover property (wr_aux && reg_wdata_i[pmsb_pkg::OFF_BIT] && off_clr);
    reset_rel_c: cover property ($rose(reset_output_pin_n_o));

endmodule
`default_nettype wire

/* File: common/pmsb_pkg.sv */
// Package: offsets, field positions, reset values and timing for the supervisor and converter-1 bank.
package pmsb_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_SYS_CTRL = 8'h00;
    localparam logic [7:0] OFF_SYS_AUX = 8'h01;
    localparam logic [7:0] OFF_C1_VPRI = 8'h20;
    localparam logic [7:0] OFF_C1_VSEC = 8'h21;
    localparam logic [7:0] OFF_C1_CTL = 8'h22;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int TRST_BIT = 7;
    localparam int RESP_BIT = 6;
    localparam int UNMASK_BIT = 5;
    localparam int LSFLAG_BIT = 4;
    localparam int OFF_BIT = 5;
    localparam int ON_BIT = 7;
    localparam int PHASE_BIT = 6;
    localparam int MODE_BIT = 5;
    localparam int DLY_LSB = 2;
    localparam int FLTEN_BIT = 1;
    localparam int PGOOD_BIT = 0;

    // ----------------------------------------
    // Writable-bit masks and reset values
    // ----------------------------------------
    localparam logic [7:0] MASK_SYS_CTRL = 8'hEF;
    localparam logic [7:0] MASK_SYS_AUX = 8'hFF;
    localparam logic [7:0] MASK_VCODE = 8'h3F;
    localparam logic [7:0] MASK_C1_CTL = 8'hFE;
    localparam logic [7:0] RST_SYS_CTRL = 8'h00;
    localparam logic [7:0] RST_SYS_AUX = 8'h00;
    localparam logic [7:0] RST_C1_VPRI = 8'h18;
    localparam logic [7:0] RST_C1_VSEC = 8'h19;
    localparam logic [7:0] RST_C1_CTL = 8'h80;

    // ----------------------------------------
    // Reset time-out figures
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int TOUT_SHORT_MS = 65;
    localparam int TOUT_LONG_MS = 260;
    localparam int TOUT_SHORT_CYC = TOUT_SHORT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TOUT_LONG_CYC = TOUT_LONG_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TCNT_W = 26;

    // Reset output sequencer states.
    typedef enum logic [1:0] {
        RT_HOLD = 2'b00,
        RT_COUNT = 2'b01,
        RT_DONE = 2'b10
    } pmsb_rt_state_e;

endpackage

/* File: rtl/pmsb_rst_timer.sv */
// Reset output timer: holds the reset pin low until the chosen time-out has run after supply is good.
`timescale 1ns/10ps
`default_nettype none

module pmsb_rst_timer #(
    parameter int SHORT_CYC = pmsb_pkg::TOUT_SHORT_CYC,
    parameter int LONG_CYC = pmsb_pkg::TOUT_LONG_CYC
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Control.
    input wire logic supply_ok_i,
    input wire logic short_sel_i,
    // Reset pin level, low while held.
    output logic reset_out_n_o
);

    pmsb_pkg::pmsb_rt_state_e st_q, st_d;
    logic [pmsb_pkg::TCNT_W-1:0] cnt_q, cnt_d;
    logic [pmsb_pkg::TCNT_W-1:0] lim_q, lim_d;
    logic rel_q, rel_d;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // The limit is latched at the start so a rewrite mid-count cannot shorten a running time-out.
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        lim_d = lim_q;
        unique case (st_q)
            pmsb_pkg::RT_HOLD: begin
                cnt_d = '0;
                lim_d = short_sel_i ? pmsb_pkg::TCNT_W'(SHORT_CYC - 1) : pmsb_pkg::TCNT_W'(LONG_CYC - 1);
                if (supply_ok_i) begin
                    st_d = pmsb_pkg::RT_COUNT;
                end
            end
            pmsb_pkg::RT_COUNT: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == lim_q) begin
                    st_d = pmsb_pkg::RT_DONE;
                end
            end
            pmsb_pkg::RT_DONE: begin
                cnt_d = cnt_q;
            end
            default: begin
                st_d = pmsb_pkg::RT_HOLD;
            end
        endcase
        if (!supply_ok_i) begin
            st_d = pmsb_pkg::RT_HOLD;
        end
        rel_d = (st_d == pmsb_pkg::RT_DONE);
    end

    // Registers of the sequencer.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= pmsb_pkg::RT_HOLD;
            cnt_q <= '0;
            lim_q <= '0;
            rel_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            lim_q <= lim_d;
            rel_q <= rel_d;
        end
    end

    assign reset_out_n_o = rel_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    release_time_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(reset_out_n_o) |-> $past(cnt_q) == $past(lim_q))
        else $error("reset released before the time-out ran");

endmodule
`default_nettype wire

/* File: dv/pmsb_host.sv */
// Host model: issues single-byte writes and reads on the bank's register port.
`timescale 1ns/10ps
`default_nettype none

module pmsb_host (
    // Clock.
    input wire logic ref_clk_i,
    // Register port towards the bank.
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    // Idle lines carry the inverse of the last value, so a stale address never passes for a held one.
    initial begin
        reg_addr_o = 8'hA5;
        reg_wdata_o = 8'h5A;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    // One write strobe; gap adds idle cycles so both prompt and slow hosts are seen.
    task automatic wr(input int gap, input logic [7:0] a, input logic [7:0] d);
        repeat (gap) @(posedge ref_clk_i);
        @(posedge ref_clk_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask

    // One read strobe; the answer stands for the cycle after the taking edge.
    task automatic rd(input int gap, input logic [7:0] a, output logic [7:0] d, output logic ok);
        repeat (gap) @(posedge ref_clk_i);
        @(posedge ref_clk_i);
        #1;
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        ok = reg_rvalid_i;
        d = reg_rdata_i;
    endtask
endmodule

`default_nettype wire

/* File: dv/tb_pmsb_regs.sv */
// Self-checking bench for the supervisor and converter-1 register bank.
`timescale 1ns/10ps
`default_nettype none

module tb_pmsb_regs;
    // ----------------------------------------
    // Signals and model
    // ----------------------------------------
    localparam int SHORT = 20;
    localparam int LONG = 80;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd, rvalid;
    logic uvlo, sok, ls, pb, chg, bank, pg, flt;
    logic rpin, irq, shut, aoff, en, ph, ff;
    logic [3:0] thr;
    logic [5:0] vout;
    logic [2:0] dly;
    int mdl[int];
    int msk[int];
    int bad_count = 0;
    int cmp_count = 0;
    int n;
    int a;

    pmsb_host host_u (.ref_clk_i(ref_clk_i), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
        .reg_rd_o(rd), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

    pmsb_regs #(.AUTO_CLEAR_OFF(1'b1), .SHORT_CYC(SHORT), .LONG_CYC(LONG)) dut_u (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .uvlo_i(uvlo),
        .supply_ok_i(sok), .low_supply_i(ls), .pushbutton_input_i(pb), .charger_input_valid_i(chg),
        .voltage_bank_select_pin_i(bank), .power_good_i(pg), .fault_event_i(flt),
        .reset_output_pin_n_o(rpin), .supply_threshold_code_o(thr), .irq_o(irq), .shutdown_o(shut),
        .all_outputs_off_o(aoff), .vout_code_o(vout), .conv_enable_o(en), .conv_phase_o(ph),
        .conv_fixed_freq_o(ff), .conv_delay_o(dly));

    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Model defaults, also what undervoltage restores.
    task automatic mdl_rst();
        mdl[8'h00] = pmsb_pkg::RST_SYS_CTRL;
        mdl[8'h01] = pmsb_pkg::RST_SYS_AUX;
        mdl[8'h20] = pmsb_pkg::RST_C1_VPRI;
        mdl[8'h21] = pmsb_pkg::RST_C1_VSEC;
        mdl[8'h22] = pmsb_pkg::RST_C1_CTL;
    endtask

    task automatic w(input logic [7:0] ad, input logic [7:0] d);
        host_u.wr($urandom % 3, ad, d);
        if (mdl.exists(ad)) begin
            mdl[ad] = (mdl[ad] & ~msk[ad]) | (d & msk[ad]);
        end
    endtask

    // Unmapped places read zero; status bits are live.
    task automatic rdchk(input logic [7:0] ad);
        logic [7:0] d;
        logic ok;
        logic [7:0] e;
        host_u.rd($urandom % 3, ad, d, ok);
        e = mdl.exists(ad) ? 8'(mdl[ad]) : 8'h00;
        if (ad == 8'h00) e[4] = ls;
        if (ad == 8'h22) e[0] = pg;
        chk({7'h00, ok}, 8'h01);
        chk(d, e);
    endtask

    task automatic settle();
        repeat (2) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic outchk();
        int c;
        int k;
        c = mdl[8'h00];
        k = mdl[8'h22];
        chk(thr, c[3:0]);
        chk(vout, 8'(bank ? mdl[8'h21] : mdl[8'h20]));
        chk(en, k[7]);
        chk(ph, k[6]);
        chk(ff, k[5]);
        chk(dly, k[4:2]);
        c = mdl[8'h01];
        chk(aoff, c[5]);
        c = mdl[8'h00];
        chk(irq, (ls & c[6] & c[5]) | (flt & k[1]));
        chk(shut, ls & ~c[6]);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {uvlo, sok, ls, pb, chg, bank, pg, flt} = 8'h00;
        mdl_rst();
        msk[8'h00] = pmsb_pkg::MASK_SYS_CTRL;
        msk[8'h01] = pmsb_pkg::MASK_SYS_AUX;
        msk[8'h20] = pmsb_pkg::MASK_VCODE;
        msk[8'h21] = pmsb_pkg::MASK_VCODE;
        msk[8'h22] = pmsb_pkg::MASK_C1_CTL;
        void'($urandom(12463));
        repeat (16) @(posedge ref_clk_i);
        #1;
        rst_n_i = 1'b1;
        foreach (msk[i]) rdchk(i[7:0]);
        rdchk(8'h02);
        rdchk(8'hFF);
        outchk();
        chk(rpin, 1'b0);
        $display("test defaults done");
        // Random traffic; the bank pin and status inputs wander meanwhile.
        for (int i = 0; i < 40; i++) begin
            {ls, pg, bank, flt} = 4'($urandom);
            a = $urandom % 5;
            a = (a < 2) ? a : a + 30;
            w(a[7:0], 8'($urandom));
            settle();
            outchk();
            rdchk(a[7:0]);
        end
        $display("test random access done");
        // Every mode, mask and fault combination
        for (int k = 0; k < 32; k++) begin
            w(8'h00, {1'b0, k[0], k[1], 5'h03});
            w(8'h22, {6'h20, k[2], 1'b0});
            ls = k[3];
            flt = k[4];
            settle();
            outchk();
            rdchk(8'h00);
        end
        {ls, flt} = 2'b00;
        $display("test interrupt combinations done");
        // Master off cleared by button, then by charger
        for (int s = 0; s < 2; s++) begin
            w(8'h01, 8'h2F);
            settle();
            outchk();
            pb = (s == 0);
            chg = (s == 1);
            mdl[8'h01] = mdl[8'h01] & 8'hDF;
            settle();
            outchk();
            rdchk(8'h01);
            {pb, chg} = 2'b00;
        end
        $display("test master off done");
        w(8'h00, 8'hEF);
        w(8'h01, 8'hDF);
        w(8'h20, 8'h3F);
        w(8'h21, 8'h01);
        w(8'h22, 8'h7E);
        uvlo = 1'b1;
        settle();
        uvlo = 1'b0;
        mdl_rst();
        outchk();
        foreach (msk[i]) rdchk(i[7:0]);
        $display("test undervoltage done");
        for (int s = 1; s >= 0; s--) begin
            w(8'h00, {s[0], 7'h00});
            sok = 1'b1;
            n = 0;
            while (rpin !== 1'b1 && n < 200) begin
                @(posedge ref_clk_i);
                #1;
                n++;
            end
            // A release that never comes counts once and goes straight to the verdict.
            if (n >= 200) begin
                bad_count++;
                break;
            end
            // The pin rises on the edge that ends the last counted cycle; the first polled edge only leaves the hold state.
            chk(n[7:0], 8'(s ? SHORT + 1 : LONG + 1));
            sok = 1'b0;
            settle();
            chk(rpin, 1'b0);
        end
        $display("test reset timer done");
        results();
    end
endmodule

`default_nettype wire
